/* File: core/fcsm_defines.svh */
// Offsets, field positions, command codes and timing counts of the flash host controller.
// Assumes inclusion by bare name from the core files.
`ifndef FCSM_DEFINES_SVH
`define FCSM_DEFINES_SVH

// APB register byte offsets
`define FCSM_REG_CTRL      12'h000
`define FCSM_REG_ADDR      12'h004
`define FCSM_REG_WDATA     12'h008
`define FCSM_REG_STATUS    12'h00C
`define FCSM_REG_RDATA     12'h010

// Control register fields
`define FCSM_CTRL_GO       0
`define FCSM_CTRL_OP_LSB   4
`define FCSM_CTRL_OP_MSB   7

// Status register fields
`define FCSM_ST_BUSY       0
`define FCSM_ST_DONE       1
`define FCSM_ST_TIMEOUT    2
`define FCSM_ST_TOGGLING   3

// Flash command codes and unlock addresses
`define FCSM_ADDR_UNLOCK1  17'h00555
`define FCSM_ADDR_UNLOCK2  17'h002AA
`define FCSM_CODE_UNLOCK1  8'hAA
`define FCSM_CODE_UNLOCK2  8'h55
`define FCSM_CODE_AUTOSEL  8'h90
`define FCSM_CODE_PROGRAM  8'hA0
`define FCSM_CODE_ERASE    8'h80
`define FCSM_CODE_CHIP     8'h10
`define FCSM_CODE_SECTOR   8'h30
`define FCSM_CODE_SUSPEND  8'hB0
`define FCSM_CODE_RESUME   8'h30
`define FCSM_CODE_RESET    8'hF0

// Data line positions of the status bits
`define FCSM_POLL_BIT      7
`define FCSM_TOGGLE_BIT    6
`define FCSM_TIMEOUT_BIT   5

// Strobe timing: 60 ns phase at 20 ns clock period
`define FCSM_PHASE_NS      60
`define FCSM_CLK_NS        20
`define FCSM_PHASE_CYC     ((`FCSM_PHASE_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)

`endif

/* File: core/fcsm_pkg.sv */
// Types shared by the flash host controller.
// Assumes nothing of its surroundings.
package fcsm_pkg;
	typedef enum logic [3:0] {
		FCSM_OP_READ,
		FCSM_OP_RESET,
		FCSM_OP_AUTOSEL,
		FCSM_OP_PROGRAM,
		FCSM_OP_CHIP,
		FCSM_OP_SECTOR,
		FCSM_OP_SUSPEND,
		FCSM_OP_RESUME,
		FCSM_OP_POLL
	} fcsm_op_t;
endpackage

/* File: core/fcsm_bus_cycle.sv */
// One flash bus cycle: drives strobes, address and data for a read or a write.
// Assumes the flash pins are passed straight through by fcsm_host; dq_i is sampled here through three stages.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.svh"
module fcsm_bus_cycle
	import fcsm_pkg::*;
#(
	parameter int PHASE = `FCSM_PHASE_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Request
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [16:0] addr,
	input  wire logic [7:0]  wdata,
	output logic             done,
	output logic [7:0]       rdata,
	// Flash pins
	output logic             ce_n,
	output logic             we_n,
	output logic             oe_n,
	output logic [16:0]      fa,
	output logic [7:0]       dq_o,
	output logic             dq_oe,
	input  wire logic [7:0]  dq_i
);
	if (PHASE < 1 || PHASE > 255) begin : g_phase_check
		$error("PHASE out of range");
	end

	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fcsm_bc_t;
	fcsm_bc_t   st_ff;
	logic [7:0] cnt_ff;
	logic       wr_ff;
	logic [7:0] s1_ff, s2_ff, s3_ff;
	wire        cnt_end = (cnt_ff == 8'(PHASE - 1));
	wire        din_ok  = (s2_ff == s3_ff);
	// A read byte counts only once it has passed all three stages after the strobe fell
	wire        strobe_end = (cnt_ff >= 8'(PHASE - 1)) &&
	                         (wr_ff || (din_ok && cnt_ff >= 8'h03));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= 8'h00;
			s2_ff <= 8'h00;
			s3_ff <= 8'h00;
		end else begin
			s1_ff <= dq_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= BC_IDLE;
			cnt_ff <= 8'h00;
			wr_ff <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			fa <= 17'h00000;
			dq_o <= 8'h00;
			dq_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (st_ff)
				BC_IDLE: if (start) begin
					// Address settles before the strobes fall
					fa <= addr;
					dq_o <= wdata;
					wr_ff <= is_write;
					dq_oe <= is_write;
					cnt_ff <= 8'h00;
					st_ff <= BC_SETUP;
				end
				BC_SETUP: begin
					// Write: CE and WE low, OE high; read: CE and OE low
					ce_n <= 1'b0;
					we_n <= !wr_ff;
					oe_n <= wr_ff;
					st_ff <= BC_STROBE;
				end
				BC_STROBE: if (strobe_end) begin
					// Data held through the rising strobe
					if (!wr_ff) rdata <= s3_ff;
					ce_n <= 1'b1;
					we_n <= 1'b1;
					oe_n <= 1'b1;
					cnt_ff <= 8'h00;
					st_ff <= BC_HOLD;
				end else if (cnt_ff != 8'hFF) begin
					cnt_ff <= cnt_ff + 8'h01;
				end
				BC_HOLD: if (cnt_end) begin
					dq_oe <= 1'b0;
					done <= 1'b1;
					st_ff <= BC_IDLE;
				end else begin
					cnt_ff <= cnt_ff + 8'h01;
				end
			endcase
		end
	end

	property p_write_strobes;
		@(posedge pclk) disable iff (!presetn)
		(!we_n) |-> (!ce_n && oe_n && dq_oe);
	endproperty
	a_write_strobes: assert property (p_write_strobes) else $error("bad write strobes");

	property p_no_contention;
		@(posedge pclk) disable iff (!presetn)
		(!oe_n) |-> !dq_oe;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("drive while reading");

	property p_addr_stable;
		@(posedge pclk) disable iff (!presetn)
		(!ce_n && $past(!ce_n)) |-> $stable(fa) && $stable(dq_o);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("addr moved in strobe");
endmodule
`default_nettype wire

/* File: core/fcsm_host.sv */
// APB slave that takes flash orders and runs write sequences and status polls.
// Assumes one flash device on the pins, reached through fcsm_bus_cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.svh"
module fcsm_host
	import fcsm_pkg::*;
#(
	parameter int PHASE = `FCSM_PHASE_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Flash pins
	output logic             ce_n,
	output logic             we_n,
	output logic             oe_n,
	output logic [16:0]      fa,
	output logic [7:0]       dq_o,
	output logic             dq_oe,
	input  wire logic [7:0]  dq_i
);
	typedef enum logic [1:0] {H_IDLE, H_SEQ, H_WAIT, H_POLL} fcsm_hs_t;

	fcsm_hs_t    st_ff;
	fcsm_op_t    op_ff;
	logic [16:0] addr_ff;
	logic [7:0]  wdata_ff, rdata_ff, prev_ff;
	logic [2:0]  step_ff;
	logic        busy_ff, done_ff, tmo_ff, tog_ff, first_ff;
	logic        tmo_seen_ff;
	logic        bc_start_ff;
	logic        bc_done;
	logic [7:0]  bc_rdata;

	wire acc   = psel && penable;
	wire wr    = acc && pwrite;
	wire go    = wr && paddr == `FCSM_REG_CTRL && pwdata[`FCSM_CTRL_GO] && !busy_ff;
	wire hit   = paddr == `FCSM_REG_CTRL || paddr == `FCSM_REG_ADDR ||
	             paddr == `FCSM_REG_WDATA || paddr == `FCSM_REG_STATUS ||
	             paddr == `FCSM_REG_RDATA;
	wire [3:0] op_in = pwdata[`FCSM_CTRL_OP_MSB:`FCSM_CTRL_OP_LSB];

	// Number of bus cycles per order in H_SEQ
	wire [2:0] nsteps = (op_ff == FCSM_OP_PROGRAM) ? 3'd4 :
	                    (op_ff == FCSM_OP_AUTOSEL) ? 3'd3 :
	                    (op_ff == FCSM_OP_CHIP || op_ff == FCSM_OP_SECTOR) ? 3'd6 : 3'd1;
	// Sequence table of address and data per step
	wire [16:0] s_addr = (step_ff == 3'd1 || step_ff == 3'd4) ? `FCSM_ADDR_UNLOCK2 :
	                     (step_ff == 3'd3 && op_ff == FCSM_OP_PROGRAM) ? addr_ff :
	                     (step_ff == 3'd5 && op_ff == FCSM_OP_SECTOR) ? addr_ff :
	                     (nsteps == 3'd1) ? addr_ff : `FCSM_ADDR_UNLOCK1;
	wire [7:0] last_code = (op_ff == FCSM_OP_RESET)   ? `FCSM_CODE_RESET :
	                       (op_ff == FCSM_OP_SUSPEND) ? `FCSM_CODE_SUSPEND :
	                       (op_ff == FCSM_OP_RESUME)  ? `FCSM_CODE_RESUME :
	                       (op_ff == FCSM_OP_CHIP)    ? `FCSM_CODE_CHIP : `FCSM_CODE_SECTOR;
	wire unlock1_step = (step_ff == 3'd0 && nsteps > 3'd2) ||
	                    (step_ff == 3'd3 && nsteps == 3'd6);
	wire [7:0] s_data = unlock1_step ? `FCSM_CODE_UNLOCK1 :
	                    (step_ff == 3'd1 || step_ff == 3'd4) ? `FCSM_CODE_UNLOCK2 :
	                    (step_ff == 3'd2 && op_ff == FCSM_OP_AUTOSEL) ? `FCSM_CODE_AUTOSEL :
	                    (step_ff == 3'd2 && op_ff == FCSM_OP_PROGRAM) ? `FCSM_CODE_PROGRAM :
	                    (step_ff == 3'd2) ? `FCSM_CODE_ERASE :
	                    (step_ff == 3'd3) ? wdata_ff : last_code;
	wire seq_last = (step_ff == nsteps - 3'd1);
	// The closing read of a poll must stay a read, or a stray command reaches the device
	wire is_rd    = (st_ff == H_POLL) || (st_ff == H_WAIT) ||
	                (st_ff == H_SEQ && op_ff == FCSM_OP_READ);
	wire toggled  = bc_rdata[`FCSM_TOGGLE_BIT] ^ prev_ff[`FCSM_TOGGLE_BIT];

	wire [31:0] status_w = {28'h0000000, tog_ff, tmo_ff, done_ff, busy_ff};
	wire [31:0] rd_mux = (paddr == `FCSM_REG_CTRL)   ? {24'h000000, op_ff, 4'h0} :
	                     (paddr == `FCSM_REG_ADDR)   ? {15'h0000, addr_ff} :
	                     (paddr == `FCSM_REG_WDATA)  ? {24'h000000, wdata_ff} :
	                     (paddr == `FCSM_REG_STATUS) ? status_w :
	                     (paddr == `FCSM_REG_RDATA)  ? {24'h000000, rdata_ff} : 32'h00000000;

	fcsm_bus_cycle #(.PHASE(PHASE)) u_bc (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (bc_start_ff),
		.is_write(!is_rd),
		.addr    (s_addr),
		.wdata   (s_data),
		.done    (bc_done),
		.rdata   (bc_rdata),
		.ce_n    (ce_n),
		.we_n    (we_n),
		.oe_n    (oe_n),
		.fa      (fa),
		.dq_o    (dq_o),
		.dq_oe   (dq_oe),
		.dq_i    (dq_i)
	);

	// APB answers in the access cycle, zero wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= H_IDLE;
			op_ff <= FCSM_OP_READ;
			addr_ff <= 17'h00000;
			wdata_ff <= 8'h00;
			rdata_ff <= 8'h00;
			prev_ff <= 8'h00;
			step_ff <= 3'd0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			tmo_ff <= 1'b0;
			tog_ff <= 1'b0;
			first_ff <= 1'b0;
			tmo_seen_ff <= 1'b0;
			bc_start_ff <= 1'b0;
		end else begin
			bc_start_ff <= 1'b0;
			if (wr && paddr == `FCSM_REG_ADDR && !busy_ff) addr_ff <= pwdata[16:0];
			if (wr && paddr == `FCSM_REG_WDATA && !busy_ff) wdata_ff <= pwdata[7:0];
			// Hardware setting of done wins over software clear
			if (wr && paddr == `FCSM_REG_STATUS && pwdata[`FCSM_ST_DONE]) done_ff <= 1'b0;
			unique case (st_ff)
				H_IDLE: if (go) begin
					op_ff <= fcsm_op_t'(op_in);
					step_ff <= 3'd0;
					busy_ff <= 1'b1;
					done_ff <= 1'b0;
					tog_ff <= 1'b0;
					first_ff <= 1'b1;
					tmo_seen_ff <= 1'b0;
					bc_start_ff <= 1'b1;
					st_ff <= (fcsm_op_t'(op_in) == FCSM_OP_POLL) ? H_POLL : H_SEQ;
				end
				H_SEQ: if (bc_done) begin
					if (op_ff == FCSM_OP_READ) rdata_ff <= bc_rdata;
					if (op_ff == FCSM_OP_RESET) tmo_ff <= 1'b0;
					if (seq_last) begin
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						st_ff <= H_IDLE;
					end else begin
						step_ff <= step_ff + 3'd1;
						bc_start_ff <= 1'b1;
					end
				end
				H_POLL: if (bc_done) begin
					// Toggle detection over two reads
					prev_ff <= bc_rdata;
					rdata_ff <= bc_rdata;
					first_ff <= 1'b0;
					if (!first_ff && !toggled) begin
						// One more read for all eight lines
						st_ff <= H_WAIT;
						bc_start_ff <= 1'b1;
					end else if (!first_ff && tmo_seen_ff) begin
						// Still toggling one read after the flag rose: failed
						tog_ff <= 1'b1;
						tmo_ff <= 1'b1;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						st_ff <= H_IDLE;
					end else begin
						if (!first_ff) tog_ff <= 1'b1;
						// Flag may rise just as toggling stops, so look once more
						if (!first_ff) tmo_seen_ff <= bc_rdata[`FCSM_TIMEOUT_BIT];
						bc_start_ff <= 1'b1;
					end
				end
				H_WAIT: if (bc_done) begin
					rdata_ff <= bc_rdata;
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
					st_ff <= H_IDLE;
				end
			endcase
		end
	end

	property p_busy_clears;
		@(posedge pclk) disable iff (!presetn)
		$fell(busy_ff) |-> done_ff;
	endproperty
	a_busy_clears: assert property (p_busy_clears) else $error("busy fell without done");

	property p_reset_clears_tmo;
		@(posedge pclk) disable iff (!presetn)
		(st_ff == H_SEQ && op_ff == FCSM_OP_RESET && bc_done) |=> !tmo_ff;
	endproperty
	a_reset_clears_tmo: assert property (p_reset_clears_tmo) else $error("timeout kept");

	property p_pready_one;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_pready_one: assert property (p_pready_one) else $error("pready not one cycle");
endmodule
`default_nettype wire

/* File: verification/fcsm_flash_model.sv */
// Behavioural flash device: command decoder, array and embedded-operation status bytes.
// Assumes the bench resolves the data bus and feeds the resolved byte on dq_w.
`timescale 1ns/1ps
`default_nettype none
module fcsm_flash_model #(
	parameter logic [7:0] MFG_CODE = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'hC3, // Arbitrary value
	parameter int         OP_READS = 4,     // Status reads per embedded operation
	parameter logic [4:0] PROT_SEC = 5'h1E  // Protected sector
) (
	// Strobes
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	// Address and data
	input  wire logic [16:0] fa,
	input  wire logic [7:0]  dq_w,
	output logic [7:0]       dq_i
);
	logic [7:0]  mem [0:131071];
	logic [7:0]  q;
	logic [7:0]  program_data;
	logic [16:0] alat;
	logic [16:0] program_address;
	logic [4:0]  sector_address;
	logic        tog;
	logic        to;
	logic        chip;
	int          st;
	int          s;
	int          n;
	wire         wr = !ce_n && !we_n && oe_n;
	wire         rd = !ce_n && !oe_n;
	// Released bus shows the inverse of the last byte
	assign dq_i = rd ? q : ~q;
	initial begin
		for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
		st = 0;
		s = 0;
		tog = 1'b0;
		to = 1'b0;
		q = 8'h00;
	end
	task automatic complete_op();
		if (st == 3) begin
			for (int i = 0; i < 131072; i++)
				if ((chip || i[16:12] == sector_address) && i[16:12] != PROT_SEC)
					mem[i] = 8'hFF;
			st = 0;
		end else begin
			// Protected sector: status toggles, data stays
			if (program_address[16:12] != PROT_SEC)
				mem[program_address] = mem[program_address] & program_data;
			st = (st == 5) ? 4 : 0;
		end
	endtask
	task automatic take(input logic [16:0] a, input logic [7:0] d);
		logic u1;
		logic u2;
		u1 = a[10:0] == 11'h555;
		u2 = a[10:0] == 11'h2AA;
		if (to) begin
			if (d == 8'hF0) begin
				st = 0;
				to = 1'b0;
			end
		end else if (st == 3) begin
			if (!chip && d == 8'hB0) st = 4;
		end else if (st == 2 || st == 5) begin
			s = 0;
		end else if (d == 8'hF0) begin
			s = 0;
			if (st == 1) st = 0;
		end else if (st == 4 && s == 0 && d == 8'h30) begin
			st = 3;
		end else case (s)
			0, 4: s = (u1 && d == 8'hAA) ? s + 1 : 0;
			1, 5: s = (u2 && d == 8'h55) ? s + 1 : 0;
			2: begin
				if (u1 && d == 8'h90 && st != 4) st = 1;
				s = (u1 && d == 8'hA0) ? 3 : (u1 && d == 8'h80 && st != 4) ? 4 : 0;
			end
			3: begin
				program_address = a;
				program_data = d;
				to = |(d & ~mem[a]);
				st = (st == 4) ? 5 : 2;
				n = OP_READS;
				s = 0;
			end
			default: begin
				chip = u1 && d == 8'h10;
				sector_address = a[16:12];
				if (chip || d == 8'h30) st = 3;
				n = OP_READS;
				s = 0;
			end
		endcase
	endtask
	always @(posedge wr) alat = fa;
	always @(negedge wr) if (oe_n) take(alat, dq_w);
	always @(posedge rd) begin
		case (st)
			1: q = (fa[7:0] == 8'h00) ? MFG_CODE : (fa[7:0] == 8'h01) ? DEV_CODE : 8'h00;
			2, 3, 5: begin
				tog = !tog;
				q = {(st == 3) ? 1'b0 : !program_data[7], tog, to, 5'h00};
				if (!to && n > 0) n--;
				// Status byte on the finishing read, data from the next
				if (!to && n == 0) complete_op();
			end
			4: q = (fa[16:12] == sector_address) ? 8'h80 : mem[fa];
			default: q = mem[fa];
		endcase
	end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the flash host controller against a behavioural flash model.
// Assumes the core files and the flash model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.svh"
module tb_top import fcsm_pkg::*; ;
	localparam logic [7:0] MFG = 8'h3C; // Arbitrary value
	localparam logic [7:0] DEV = 8'hC3; // Arbitrary value
	localparam logic [4:0] PROT = 5'h1E; // Protected sector of the model
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         ce_n;
	wire         we_n;
	wire         oe_n;
	wire  [16:0] fa;
	wire  [7:0]  dq_o;
	wire         dq_oe;
	wire  [7:0]  mdl_q;
	wire  [7:0]  dq_bus = dq_oe ? dq_o : mdl_q;
	logic [15:0] lf;
	logic [31:0] ers;
	int          em [int];
	int          fail_count;
	int          compares;
	int          cyc_cnt;
	fcsm_host #(.PHASE(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .fa(fa), .dq_o(dq_o),
		.dq_oe(dq_oe), .dq_i(dq_bus));
	fcsm_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV), .OP_READS(4), .PROT_SEC(PROT)) flash (
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .fa(fa), .dq_w(dq_bus), .dq_i(mdl_q));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [7:0] exp_rd(input logic [16:0] a);
		if (em.exists(a)) return em[a][7:0];
		if (ers[a[16:12]]) return 8'hFF;
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	task automatic complete_run();
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		logic got;
		got = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Request holds until the rising edge at which pready is sampled high
		while (!got) begin
			@(posedge pclk);
			got = pready === 1'b1;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_op(input fcsm_op_t op, input logic [16:0] a, input logic [7:0] d,
		output logic [31:0] st);
		logic        e;
		logic [31:0] r;
		apb(1'b1, `FCSM_REG_ADDR, {15'h0000, a}, r, e);
		apb(1'b1, `FCSM_REG_WDATA, {24'h000000, d}, r, e);
		apb(1'b1, `FCSM_REG_CTRL, {24'h000000, op, 4'h1}, r, e);
		st = 32'h1;
		for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) apb(1'b0, `FCSM_REG_STATUS, 0, st, e);
		chk({30'h0, st[1:0]}, 32'h2);
		apb(1'b1, `FCSM_REG_STATUS, 32'h2, r, e);
	endtask
	task automatic rd_flash(input logic [16:0] a, output logic [7:0] v);
		logic [31:0] st;
		logic [31:0] r;
		logic        e;
		do_op(FCSM_OP_READ, a, 8'h00, st);
		apb(1'b0, `FCSM_REG_RDATA, 0, r, e);
		v = r[7:0];
	endtask
	task automatic chk_rd(input logic [16:0] a, input logic [7:0] exp, input logic [7:0] m);
		logic [7:0] v;
		rd_flash(a, v);
		chk({24'h0, v & m}, {24'h0, exp & m});
	endtask
	task automatic chk_poll(input logic [16:0] a, input logic [1:0] exp);
		logic [31:0] st;
		do_op(FCSM_OP_POLL, a, 8'h00, st);
		chk({30'h0, st[3:2]}, {30'h0, exp});
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		logic [31:0] st;
		logic [31:0] r;
		logic [16:0] a;
		logic [16:0] a1;
		logic [16:0] a2;
		logic [7:0]  d;
		logic [7:0]  old;
		logic        e;
		{psel, penable, pwrite, paddr, pwdata} = 0;
		presetn = 1'b0;
		lf = 16'h236A;
		ers = 0;
		fail_count = 0;
		compares = 0;
		cyc_cnt = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `FCSM_REG_STATUS, 0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 12'h020, 0, r, e);
		chk({r[30:0], e}, 32'h1);
		for (int k = 0; k < 3; k++) begin
			lf = lfsr(lf);
			chk_rd({1'b0, lf}, exp_rd({1'b0, lf}), 8'hFF);
		end
		lf = lfsr(lf);
		a1 = {5'h01, lf[11:0]};
		d = exp_rd(a1) & lf[15:8];
		do_op(FCSM_OP_PROGRAM, a1, d, st);
		em[a1] = d;
		chk_poll(a1, 2'b10);
		apb(1'b0, `FCSM_REG_RDATA, 0, r, e);
		chk(r & 32'hFF, {24'h0, d});
		chk_rd(a1, d, 8'hFF);
		a = {5'h01, ~lf[11:0]};
		if (exp_rd(a) == 8'hFF) a[0] = ~a[0];
		old = exp_rd(a);
		do_op(FCSM_OP_PROGRAM, a, ~old, st);
		chk_poll(a, 2'b11);
		do_op(FCSM_OP_RESET, a, 8'h00, st);
		chk({31'h0, st[2]}, 32'h0);
		chk_rd(a, old, 8'hFF);
		do_op(FCSM_OP_AUTOSEL, 17'h00000, 8'h00, st);
		chk_rd(17'h00000, MFG, 8'hFF);
		chk_rd(17'h00001, DEV, 8'hFF);
		chk_rd(17'h00000, MFG, 8'hFF);
		do_op(FCSM_OP_RESET, 17'h00000, 8'h00, st);
		chk_rd(17'h00000, exp_rd(17'h00000), 8'hFF);
		lf = lfsr(lf);
		a = {5'h05, lf[11:0]};
		a2 = {5'h02, lf[11:0]};
		do_op(FCSM_OP_SECTOR, a, 8'h00, st);
		do_op(FCSM_OP_SUSPEND, {5'h1F, lf[11:0]}, 8'h00, st);
		chk_rd({5'h05, ~lf[11:0]}, 8'h80, 8'h80);
		chk_rd(a2, exp_rd(a2), 8'hFF);
		d = exp_rd(a2) & lf[7:0];
		do_op(FCSM_OP_PROGRAM, a2, d, st);
		em[a2] = d;
		chk_poll(a2, 2'b10);
		chk_rd(a2, d, 8'hFF);
		do_op(FCSM_OP_AUTOSEL, 17'h00000, 8'h00, st);
		chk_rd(a2, d, 8'hFF);
		do_op(FCSM_OP_RESUME, {5'h1F, ~lf[11:0]}, 8'h00, st);
		do_op(FCSM_OP_RESUME, 17'h00000, 8'h00, st);
		chk_poll(a, 2'b10);
		ers[5] = 1'b1;
		chk_rd({5'h05, ~lf[11:0]}, 8'hFF, 8'hFF);
		chk_rd({5'h04, lf[11:0]}, exp_rd({5'h04, lf[11:0]}), 8'hFF);
		a = {PROT, lf[11:0]};
		old = exp_rd(a);
		do_op(FCSM_OP_PROGRAM, a, old & 8'h0F, st);
		chk_poll(a, 2'b10);
		chk_rd(a, old, 8'hFF);
		do_op(FCSM_OP_CHIP, 17'h00000, 8'h00, st);
		do_op(FCSM_OP_SUSPEND, 17'h00000, 8'h00, st);
		chk_poll(a1, 2'b10);
		em.delete();
		// Every sector but the protected one is erased
		ers = 32'hBFFFFFFF;
		chk_rd(a1, 8'hFF, 8'hFF);
		chk_poll(a2, 2'b00);
		complete_run();
	end
endmodule
`default_nettype wire
